// File: acr_pkg.sv
// Constants for the monitor-control and fault-mask register bank.
// Assumes an internal register port already decoded from the serial bus.
// Notes on behaviour
// [RL1] Short-circuit mask bit 7 blocks its interrupt
// [RL2] Overvoltage mask bit 6 blocks its interrupt
// [RL3] Thermal-trip mask bit 2 blocks its interrupt
// [RL4] Enable bit 7; watchdog and reset clear
// [RL5] Rate bit 6: continuous or one-shot
// [RL6] Speed field 5-4 picks resolution, resets 11b
// [RL7] Bit 3 selects running average
// [RL8] Bit 2 seeds average from fresh conversion
// [RL9] First channel-off register, bits 7 to 1
// [RL10] Second channel-off register, bits 7 to 4
// [RL11] Control resets 30h, others 0h
// [RL12] Unmasked event gives one-cycle interrupt pulse
// [RL13] Reserved read-only bits read zero
package acr_pkg;
  localparam logic [7:0] ACR_OFF_FMASK = 8'h2D;
  localparam logic [7:0] ACR_OFF_CTRL = 8'h2E;
  localparam logic [7:0] ACR_OFF_CHA = 8'h2F;
  localparam logic [7:0] ACR_OFF_CHB = 8'h30;
  localparam logic [7:0] ACR_RST_FMASK = 8'h00;
  localparam logic [7:0] ACR_RST_CTRL = 8'h30;
  localparam logic [7:0] ACR_RST_CHA = 8'h00;
  localparam logic [7:0] ACR_RST_CHB = 8'h00;
  // Writable bits of each register; the rest read zero
  localparam logic [7:0] ACR_WM_FMASK = 8'hFC;
  localparam logic [7:0] ACR_WM_CTRL = 8'hFF;
  localparam logic [7:0] ACR_WM_CHA = 8'hFE;
  localparam logic [7:0] ACR_WM_CHB = 8'hF0;
  localparam int ACR_B_SHORT = 7;
  localparam int ACR_B_OVP = 6;
  localparam int ACR_B_TRIP = 2;
  localparam int ACR_B_EN = 7;
  localparam int ACR_B_RATE = 6;
  localparam int ACR_B_SPD = 4;
  localparam int ACR_B_AVG = 3;
  localparam int ACR_B_SEED = 2;
endpackage : acr_pkg

// File: acr_regs.sv
// Register bank: fault interrupt masks and monitor converter control.
// Assumes a one-cycle write strobe and a combinational-free read port;
// fault events arrive as pins from analog and are synchronised here.
`timescale 1ns/10ps
module acr_regs
  import acr_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Register port
  input wire logic WR_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  // Default restore sources, one-cycle pulses
  input wire logic REG_RESET_I,
  input wire logic WATCHDOG_I,
  // Fault events from analog, asynchronous levels
  input wire logic SYS_SHORT_I,
  input wire logic SYS_OVERVOLT_I,
  input wire logic THERMAL_TRIP_I,
  // Interrupt pulse
  output logic INT_O,
  // Converter configuration
  output logic MON_EN_O,
  output logic MON_ONESHOT_O,
  output logic [1:0] MON_SPEED_O,
  output logic MON_RUNNING_AVG_O,
  output logic MON_AVG_SEED_FRESH_O,
  output logic [6:0] CHAN_OFF_A_O,
  output logic [3:0] CHAN_OFF_B_O
);

  typedef struct packed {
    logic [7:0] fmask;
    logic [7:0] ctrl;
    logic [7:0] cha;
    logic [7:0] chb;
    logic [7:0] rdata;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic irq;
  } acr_state_type;

  acr_state_type st_r;
  acr_state_type st_nxt;
  logic [2:0] blk;
  logic [2:0] rise;

  function automatic logic [7:0] upd(input logic [7:0] cur,
                                     input logic [7:0] wm);
    upd = (cur & ~wm) | (WDATA_I & wm);
  endfunction : upd

  //************
  // Next state
  //************
  always_comb begin
    st_nxt = st_r;
    blk = {st_r.fmask[ACR_B_SHORT], st_r.fmask[ACR_B_OVP],
           st_r.fmask[ACR_B_TRIP]};
    // Event is the rising edge of the synchronised fault level
    rise = st_r.sync2 & ~st_r.prev;
    st_nxt.sync1 = {SYS_SHORT_I, SYS_OVERVOLT_I, THERMAL_TRIP_I};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    st_nxt.irq = |(rise & ~blk); // RL1 RL2 RL3 RL12
    if (WR_I) begin
      if (ADDR_I == ACR_OFF_FMASK) begin
        st_nxt.fmask = upd(st_r.fmask, ACR_WM_FMASK); // RL13
      end else if (ADDR_I == ACR_OFF_CTRL) begin
        st_nxt.ctrl = upd(st_r.ctrl, ACR_WM_CTRL); // RL5 RL6 RL7 RL8
      end else if (ADDR_I == ACR_OFF_CHA) begin
        st_nxt.cha = upd(st_r.cha, ACR_WM_CHA); // RL9
      end else if (ADDR_I == ACR_OFF_CHB) begin
        st_nxt.chb = upd(st_r.chb, ACR_WM_CHB); // RL10
      end
    end
    // Watchdog only clears the enable; it wins over a same-cycle write
    if (WATCHDOG_I) begin
      st_nxt.ctrl[ACR_B_EN] = 1'b0; // RL4
    end
    if (REG_RESET_I) begin
      st_nxt.fmask = ACR_RST_FMASK; // RL11
      st_nxt.ctrl = ACR_RST_CTRL;
      st_nxt.cha = ACR_RST_CHA;
      st_nxt.chb = ACR_RST_CHB;
    end
    // Read data shows stored values, registered for a flop-driven output
    if (ADDR_I == ACR_OFF_FMASK) begin
      st_nxt.rdata = st_r.fmask;
    end else if (ADDR_I == ACR_OFF_CTRL) begin
      st_nxt.rdata = st_r.ctrl;
    end else if (ADDR_I == ACR_OFF_CHA) begin
      st_nxt.rdata = st_r.cha;
    end else if (ADDR_I == ACR_OFF_CHB) begin
      st_nxt.rdata = st_r.chb;
    end else begin
      st_nxt.rdata = 8'h00;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r <= '{fmask: ACR_RST_FMASK, ctrl: ACR_RST_CTRL, cha: ACR_RST_CHA,
                chb: ACR_RST_CHB, rdata: 8'h00, sync1: 3'h0, sync2: 3'h0,
                prev: 3'h0, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  //************
  // Outputs
  //************
  assign RDATA_O = st_r.rdata;
  assign INT_O = st_r.irq;
  assign MON_EN_O = st_r.ctrl[ACR_B_EN]; // RL4
  assign MON_ONESHOT_O = st_r.ctrl[ACR_B_RATE]; // RL5
  assign MON_SPEED_O = st_r.ctrl[ACR_B_SPD +: 2]; // RL6
  assign MON_RUNNING_AVG_O = st_r.ctrl[ACR_B_AVG]; // RL7
  assign MON_AVG_SEED_FRESH_O = st_r.ctrl[ACR_B_SEED]; // RL8
  assign CHAN_OFF_A_O = st_r.cha[7:1]; // RL9
  assign CHAN_OFF_B_O = st_r.chb[7:4]; // RL10

  //************
  // Assertions
  //************
  property p_short_block;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      $rose(st_r.sync2[2]) && st_r.fmask[ACR_B_SHORT] |=> !INT_O ||
      $past(st_r.sync2[1:0] & ~st_r.prev[1:0]) != 2'b00;
  endproperty
  a_short_block: assert property (p_short_block) // RL1
    else $error("masked short fault raised interrupt");

  property p_short_pass;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      st_r.sync2[2] && !st_r.prev[2] && !st_r.fmask[ACR_B_SHORT] |=> INT_O;
  endproperty
  a_short_pass: assert property (p_short_pass) // RL1
    else $error("unmasked short fault gave no interrupt");

  property p_ovp_pass;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      st_r.sync2[1] && !st_r.prev[1] && !st_r.fmask[ACR_B_OVP] |=> INT_O;
  endproperty
  a_ovp_pass: assert property (p_ovp_pass) // RL2
    else $error("unmasked overvoltage gave no interrupt");

  property p_trip_pass;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      st_r.sync2[0] && !st_r.prev[0] && !st_r.fmask[ACR_B_TRIP] |=> INT_O;
  endproperty
  a_trip_pass: assert property (p_trip_pass) // RL3
    else $error("unmasked thermal trip gave no interrupt");

  property p_all_masked;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      (&blk) |=> !INT_O;
  endproperty
  a_all_masked: assert property (p_all_masked) // RL12
    else $error("interrupt with all sources masked");

  property p_pulse;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      INT_O |=> !INT_O || $past(rise) != 3'h0;
  endproperty
  a_pulse: assert property (p_pulse) // RL12
    else $error("interrupt held as a level");

  property p_wdog;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      WATCHDOG_I && !REG_RESET_I |=> !MON_EN_O ##0
      MON_SPEED_O == $past(st_r.ctrl[5:4]) || $past(WR_I);
  endproperty
  a_wdog: assert property (p_wdog) // RL4
    else $error("watchdog did not clear enable only");

  property p_regrst;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      REG_RESET_I |=> st_r.ctrl == ACR_RST_CTRL && st_r.fmask == 8'h00 &&
      CHAN_OFF_A_O == 7'h00 && CHAN_OFF_B_O == 4'h0;
  endproperty
  a_regrst: assert property (p_regrst) // RL11
    else $error("register reset did not restore defaults");

  property p_reserved;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      st_r.fmask[1:0] == 2'b00 && st_r.cha[0] == 1'b0 &&
      st_r.chb[3:0] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) // RL13
    else $error("reserved read-only bit set");

  property p_ctrl_wr;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == ACR_OFF_CTRL && !REG_RESET_I && !WATCHDOG_I |=>
      MON_SPEED_O == $past(WDATA_I[5:4]) &&
      MON_ONESHOT_O == $past(WDATA_I[6]) &&
      MON_RUNNING_AVG_O == $past(WDATA_I[3]) &&
      MON_AVG_SEED_FRESH_O == $past(WDATA_I[2]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) // RL5 RL6 RL7 RL8
    else $error("control write not applied");

  property p_cha_wr;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == ACR_OFF_CHA && !REG_RESET_I |=>
      CHAN_OFF_A_O == $past(WDATA_I[7:1]);
  endproperty
  a_cha_wr: assert property (p_cha_wr) // RL9
    else $error("channel-off A write not applied");

  property p_chb_wr;
    @(posedge CLK_I) disable iff (!ARST_N_I)
      WR_I && ADDR_I == ACR_OFF_CHB && !REG_RESET_I |=>
      CHAN_OFF_B_O == $past(WDATA_I[7:4]);
  endproperty
  a_chb_wr: assert property (p_chb_wr) // RL10
    else $error("channel-off B write not applied");

  c_int: cover property (@(posedge CLK_I) disable iff (!ARST_N_I) INT_O);
  c_wdog: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    MON_EN_O ##1 WATCHDOG_I ##1 !MON_EN_O);
  c_rst: cover property (@(posedge CLK_I) disable iff (!ARST_N_I)
    REG_RESET_I && st_r.ctrl != ACR_RST_CTRL);
endmodule : acr_regs

// File: acr_host.sv
// Host model: drives the decoded register port of the bank.
// Assumes the bank samples requests on rising edges of clk_i.
`timescale 1ns/10ps
module acr_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Stale data is inverted so a late sample cannot look correct
    wdata_o <= ~d;
  endtask : write
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask : read
endmodule : acr_host

// File: testbench.sv
// Self-checking bench for the fault-mask and monitor-control registers.
// Assumes acr_pkg and the host model are compiled first.
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_reset = 1'b0;
  logic watchdog = 1'b0;
  logic [2:0] fault = 3'h0;
  logic wr, int_o, en, oneshot, avg, seed;
  logic [7:0] addr, wdata, rdata, got, a;
  logic [1:0] speed;
  logic [6:0] cha;
  logic [3:0] chb;
  logic [7:0] model [4];
  int bad_count = 0;
  int n_checks = 0;
  int pulses;
  always #2 clk = ~clk;
  acr_host host (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  acr_regs uut (.CLK_I(clk), .ARST_N_I(arst_n), .WR_I(wr), .ADDR_I(addr),
    .WDATA_I(wdata), .RDATA_O(rdata), .REG_RESET_I(reg_reset),
    .WATCHDOG_I(watchdog), .SYS_SHORT_I(fault[2]),
    .SYS_OVERVOLT_I(fault[1]), .THERMAL_TRIP_I(fault[0]), .INT_O(int_o),
    .MON_EN_O(en), .MON_ONESHOT_O(oneshot), .MON_SPEED_O(speed),
    .MON_RUNNING_AVG_O(avg), .MON_AVG_SEED_FRESH_O(seed),
    .CHAN_OFF_A_O(cha), .CHAN_OFF_B_O(chb));
  // Writable bits per register, in address order
  function automatic logic [7:0] wmask(input logic [7:0] ad);
    logic [7:0] m [4] = '{8'hFC, 8'hFF, 8'hFE, 8'hF0};
    return m[ad - 8'h2D];
  endfunction : wmask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] seen);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check8
  task automatic defaults;
    model = '{8'h00, 8'h30, 8'h00, 8'h00};
  endtask : defaults
  task automatic verify_all(input string name);
    for (int i = 0; i < 4; i++) begin
      host.read(8'h2D + 8'(i), got);
      check8("readback", model[i], got);
    end
    host.read(8'h31, got);
    check8("unmapped", 8'h00, got);
    check8("ctrl pins", model[1] & 8'hFC,
           {en, oneshot, speed, avg, seed, 2'b00});
    check8("chan a", model[2] >> 1, {1'b0, cha});
    check8("chan b", model[3] >> 4, {4'h0, chb});
    $display("test %s done", name);
  endtask : verify_all
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) reg_reset <= 1'b1;
    else watchdog <= 1'b1;
    @(posedge clk);
    reg_reset <= 1'b0;
    watchdog <= 1'b0;
  endtask : pulse
  task automatic fault_run(input int src, input logic blk);
    // Mask bit 2 for the thermal trip, bit 6 overvoltage, bit 7 short
    model[0] = blk ? (8'h04 << (src == 0 ? 0 : src + 3)) : 8'h00;
    host.write(8'h2D, model[0]);
    pulses = 0;
    @(posedge clk);
    fault[src] <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1 if (int_o === 1'b1) pulses++;
    end
    @(posedge clk);
    fault[src] <= 1'b0;
    repeat (4) @(posedge clk);
    // One-cycle pulse when open, nothing when blocked
    check8("int pulses", {7'h00, !blk}, 8'(pulses));
  endtask : fault_run
  initial begin
    #40000;
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hE04E243F));
    defaults();
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    verify_all("reset values");
    for (int k = 0; k < 30; k++) begin
      a = 8'h2D + 8'($urandom_range(0, 4));
      got = (k < 4) ? 8'hFF : 8'($urandom);
      host.write(a, got);
      if (a != 8'h31) model[a - 8'h2D] = got & wmask(a);
      if (k % 6 == 5) verify_all("random writes");
    end
    for (int i = 0; i < 4; i++) host.write(8'h2D + 8'(i), 8'hFF);
    pulse(0);
    defaults();
    verify_all("register reset");
    host.write(8'h2E, 8'hFF);
    pulse(1);
    model[1] = 8'h7F;
    verify_all("watchdog");
    for (int b = 0; b < 2; b++) begin
      fault_run(2, b[0]);
      fault_run(1, b[0]);
      fault_run(0, b[0]);
    end
    $display("test fault masks done");
    stop_test();
  end
endmodule : testbench
